// File: design/ebs_ep_flags.sv
`timescale 1ns/1ps
module ebs_ep_flags
  import ebs_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  input  wire ebs_ep_event_t i_event,
  input  wire logic          i_stall_cmd,
  input  wire logic          i_unstall_cmd,
  input  wire logic          i_status_read,
  output logic               o_halt,
  output logic               o_overrun
);

  logic halt;
  logic overrun;
  logic storing;
  logic unacked;
  logic next_halt;
  logic next_overrun;
  logic next_storing;
  logic next_unacked;

  always_comb begin
    next_halt    = halt;
    next_storing = storing;
    next_unacked = unacked;
    next_overrun = overrun;
    if (i_stall_cmd) begin
      next_halt = 1'b1;
    end else if (i_unstall_cmd || i_event.setup_token) begin
      next_halt = 1'b0;
    end
    // Clear on read only once the incoming setup bytes are all stored
    if (i_status_read && !storing) begin
      next_overrun = 1'b0;
    end
    // Hardware-only set; it wins over a same-cycle read clear
    if (i_event.setup_store_start && unacked && !halt) begin
      next_overrun = 1'b1;
    end
    if (i_event.setup_store_start) begin
      next_storing = 1'b1;
    end else if (i_event.setup_store_done) begin
      next_storing = 1'b0;
      next_unacked = 1'b1;
    end
    if (i_event.setup_ack || i_stall_cmd) begin
      next_unacked = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      halt    <= 1'b0;
      overrun <= 1'b0;
      storing <= 1'b0;
      unacked <= 1'b0;
    end else begin
      halt    <= next_halt;
      overrun <= next_overrun;
      storing <= next_storing;
      unacked <= next_unacked;
    end
  end

  assign o_halt    = halt;
  assign o_overrun = overrun;

endmodule

// File: design/ebs_status_top.sv
// How it works
// - Bit 5 shows that the selected endpoint's primary buffer holds a full packet.
// - Bit 6 shows that the secondary buffer of a double-buffered endpoint is full.
// - Bit 4 gives the next expected data toggle, 0 for DATA0 and 1 for DATA1.
// - Bit 3 is set when a new setup packet overwrites unacknowledged, unstalled setup data.
// - A status read clears bit 3 only if storing of the setup data has finished.
// - Bit 2 shows that the endpoint buffer holds a received setup packet.
// - Bit 1 shows which buffer the processor accesses, 0 primary and 1 secondary.
// - Only the device's own logic sets the overrun bit, never a processor write.
// - A read-status command clears that endpoint's pending interrupt bit.
// - Bit 7 is set by stall, cleared by unstall, and cleared on a SETUP token.
// - Codes 50h to 5Fh read one status byte, one code per endpoint in order.
`timescale 1ns/1ps
module ebs_status_top
  import ebs_pkg::*;
#(
  parameter int NUM_EP = EBS_NUM_EP
)(
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_cmd_valid,
  input  wire logic [7:0]                 i_cmd_code,
  input  wire ebs_ep_state_t [NUM_EP-1:0] i_ep_state,
  input  wire ebs_ep_event_t [NUM_EP-1:0] i_ep_event,
  output logic                            o_status_valid,
  output logic [7:0]                      o_status_data,
  output logic [NUM_EP-1:0]               o_int_clear,
  output logic [NUM_EP-1:0]               o_halted
);

  logic [NUM_EP-1:0] stall_cmd;
  logic [NUM_EP-1:0] unstall_cmd;
  logic [NUM_EP-1:0] read_cmd;
  logic [NUM_EP-1:0] halt;
  logic [NUM_EP-1:0] overrun;
  logic [EBS_EP_W-1:0] sel;

  logic              status_valid;
  logic [7:0]        status_data;
  logic [NUM_EP-1:0] int_clear;
  logic [NUM_EP-1:0] halted;
  logic              next_status_valid;
  logic [7:0]        next_status_data;
  logic [NUM_EP-1:0] next_int_clear;

  assign sel = i_cmd_code[EBS_EP_W-1:0];

  // Command decode: one code per endpoint in each group
  always_comb begin
    stall_cmd   = '0;
    unstall_cmd = '0;
    read_cmd    = '0;
    if (i_cmd_valid && i_cmd_code >= EBS_CMD_READ_BASE && i_cmd_code <= EBS_CMD_READ_LAST
        && int'(sel) < NUM_EP) begin
      read_cmd[sel] = 1'b1;
    end else if (i_cmd_valid && i_cmd_code >= EBS_CMD_STALL_BASE
                 && i_cmd_code <= EBS_CMD_STALL_LAST && int'(sel) < NUM_EP) begin
      stall_cmd[sel] = 1'b1;
    end else if (i_cmd_valid && i_cmd_code >= EBS_CMD_UNST_BASE
                 && i_cmd_code <= EBS_CMD_UNST_LAST && int'(sel) < NUM_EP) begin
      unstall_cmd[sel] = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : gen_ep
      ebs_ep_flags u_flags (
        .i_ref_clk     (i_ref_clk),
        .i_rst         (i_rst),
        .i_event       (i_ep_event[g]),
        .i_stall_cmd   (stall_cmd[g]),
        .i_unstall_cmd (unstall_cmd[g]),
        .i_status_read (read_cmd[g]),
        .o_halt        (halt[g]),
        .o_overrun     (overrun[g])
      );
    end
  endgenerate

  // Status byte is captured from current state in the cycle of the read command
  always_comb begin
    next_status_valid = |read_cmd;
    next_status_data  = status_data;
    next_int_clear    = read_cmd;
    if (|read_cmd) begin
      next_status_data                  = EBS_STATUS_RESET;
      next_status_data[EBS_BIT_HALT]    = halt[sel];
      next_status_data[EBS_BIT_FULL1]   = i_ep_state[sel].secondary_buffer_full;
      next_status_data[EBS_BIT_FULL0]   = i_ep_state[sel].primary_buffer_full;
      next_status_data[EBS_BIT_TOGGLE]  = i_ep_state[sel].next_toggle_flag;
      next_status_data[EBS_BIT_OVERRUN] = overrun[sel];
      next_status_data[EBS_BIT_SETUP]   = i_ep_state[sel].setup_packet_present;
      next_status_data[EBS_BIT_PROCESSOR_BUFFER_SELECT]  = i_ep_state[sel].processor_buffer_select;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      status_valid <= 1'b0;
      status_data  <= EBS_STATUS_RESET;
      int_clear    <= '0;
      halted       <= '0;
    end else begin
      status_valid <= next_status_valid;
      status_data  <= next_status_data;
      int_clear    <= next_int_clear;
      halted       <= halt;
    end
  end

  assign o_status_valid = status_valid;
  assign o_status_data  = status_data;
  assign o_int_clear    = int_clear;
  assign o_halted       = halted;

endmodule

// File: pkg/ebs_pkg.sv
package ebs_pkg;

  localparam int          EBS_NUM_EP          = 16;
  localparam int          EBS_EP_W            = 4;
  localparam logic [7:0]  EBS_CMD_READ_BASE   = 8'h50;
  localparam logic [7:0]  EBS_CMD_READ_LAST   = 8'h5f;
  localparam logic [7:0]  EBS_CMD_STALL_BASE  = 8'h40;
  localparam logic [7:0]  EBS_CMD_STALL_LAST  = 8'h4f;
  localparam logic [7:0]  EBS_CMD_UNST_BASE   = 8'h80;
  localparam logic [7:0]  EBS_CMD_UNST_LAST   = 8'h8f;

  localparam int          EBS_BIT_HALT        = 7;
  localparam int          EBS_BIT_FULL1       = 6;
  localparam int          EBS_BIT_FULL0       = 5;
  localparam int          EBS_BIT_TOGGLE      = 4;
  localparam int          EBS_BIT_OVERRUN     = 3;
  localparam int          EBS_BIT_SETUP       = 2;
  localparam int          EBS_BIT_PROCESSOR_BUFFER_SELECT      = 1;

  localparam logic [7:0]  EBS_STATUS_RESET    = 8'h00;

  // Per-endpoint conditions reported by the buffer engine
  typedef struct packed {
    logic primary_buffer_full;
    logic secondary_buffer_full;
    logic next_toggle_flag;
    logic setup_packet_present;
    logic processor_buffer_select;
  } ebs_ep_state_t;

  // Per-endpoint events from the serial engine
  typedef struct packed {
    logic setup_token;
    logic setup_store_start;
    logic setup_store_done;
    logic setup_ack;
  } ebs_ep_event_t;

endpackage

// File: test/ebs_fw_model.sv
`timescale 1ns/1ps
module ebs_fw_model (
  input  wire logic i_ref_clk,
  output logic      o_cmd_valid,
  output logic [7:0] o_cmd_code
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 8'h00;
  end
  task automatic send(input logic [7:0] code);
    @(posedge i_ref_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_code <= code;
    @(posedge i_ref_clk);
    o_cmd_valid <= 1'b0;
    // Released code must not look like a held request
    o_cmd_code <= ~code;
    #1;
  endtask
endmodule

// File: test/ebs_status_monitor.sv
`timescale 1ns/1ps
module ebs_status_monitor
  import ebs_pkg::*;
#(parameter int NUM_EP = EBS_NUM_EP)(
  input wire logic                       i_ref_clk,
  input wire logic                       i_rst,
  input wire logic                       i_cmd_valid,
  input wire logic [7:0]                 i_cmd_code,
  input wire ebs_ep_state_t [NUM_EP-1:0] i_ep_state,
  input wire logic                       o_status_valid,
  input wire logic [7:0]                 o_status_data,
  input wire logic [NUM_EP-1:0]          o_int_clear,
  input wire logic [NUM_EP-1:0]          o_halted
);
  ebs_ep_state_t st_q;
  logic [3:0]    ep_q;
  logic          rd;
  assign rd = i_cmd_valid && i_cmd_code[7:4] == 4'h5;
  // Capture what the read was taken on, so the byte is judged against that edge
  always_ff @(posedge i_ref_clk) begin
    st_q <= i_ep_state[i_cmd_code[3:0]];
    ep_q <= i_cmd_code[3:0];
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  AST_RD_ANSWER: assert property (rd |=> o_status_valid) else $error("no answer");
  AST_FULL0: assert property (rd |=> o_status_data[5] == st_q.primary_buffer_full) else $error("f0");
  AST_FULL1: assert property (rd |=> o_status_data[6] == st_q.secondary_buffer_full) else $error("f1");
  AST_TOGGLE: assert property (rd |=> o_status_data[4] == st_q.next_toggle_flag) else $error("tg");
  AST_SETUP: assert property (rd |=> o_status_data[2] == st_q.setup_packet_present) else $error("su");
  AST_PROCESSOR_BUFFER_SELECT: assert property (rd |=> o_status_data[1:0] == {st_q.processor_buffer_select, 1'b0})
    else $error("cb");
  AST_INT_CLR: assert property (rd |=> o_int_clear == NUM_EP'(1) << ep_q) else $error("ic");
  AST_HALT: assert property (i_cmd_valid && i_cmd_code[7:4] == 4'h4
    |-> ##2 o_halted[$past(i_cmd_code[3:0], 2)]) else $error("ht");
endmodule
bind ebs_status_top ebs_status_monitor #(.NUM_EP(NUM_EP)) u_mon (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_ep_state(i_ep_state),
  .o_status_valid(o_status_valid), .o_status_data(o_status_data), .o_int_clear(o_int_clear),
  .o_halted(o_halted));

// File: test/endpoint_buffer_status_tb.sv
`timescale 1ns/1ps
module endpoint_buffer_status_tb;
  import ebs_pkg::*;
  logic i_ref_clk, i_rst, cv, o_status_valid;
  logic [7:0] cc, o_status_data;
  logic [15:0] o_int_clear, o_halted;
  ebs_ep_state_t [15:0] st;
  ebs_ep_event_t [15:0] ev;
  int n_errors = 0;
  int total_checks = 0;
  ebs_status_top uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_valid(cv), .i_cmd_code(cc),
    .i_ep_state(st), .i_ep_event(ev), .o_status_valid(o_status_valid),
    .o_status_data(o_status_data), .o_int_clear(o_int_clear), .o_halted(o_halted));
  ebs_fw_model fw (.i_ref_clk(i_ref_clk), .o_cmd_valid(cv), .o_cmd_code(cc));
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [7:0] xb(ebs_ep_state_t s, logic h, logic o);
    return {h, s.secondary_buffer_full, s.primary_buffer_full, s.next_toggle_flag, o,
            s.setup_packet_present, s.processor_buffer_select, 1'b0};
  endfunction
  task automatic pulse(input int e, input int b);
    @(posedge i_ref_clk);
    ev[e][b] <= 1'b1;
    @(posedge i_ref_clk);
    ev <= '0;
  endtask
  task automatic rd(input int e, input logic h, input logic o);
    fw.send(8'h50 | 8'(e));
    chk("valid", 16'(o_status_valid), 16'h1);
    chk("int_clear", o_int_clear, 16'h1 << e);
    chk("status", 16'(o_status_data), 16'(xb(st[e], h, o)));
  endtask
  initial begin
    #50us;
    n_errors++;
    end_sim();
  end
  initial begin
    i_rst = 1'b1;
    st = '0;
    ev = '0;
    void'($urandom(32'hdf8b));
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(5, 1'b0, 1'b0);
    pulse(0, 2);
    pulse(0, 1);
    pulse(0, 2);
    // Overrun is read before any acknowledge; store still running keeps it set
    rd(0, 1'b0, 1'b1);
    rd(0, 1'b0, 1'b1);
    pulse(0, 1);
    rd(0, 1'b0, 1'b1);
    rd(0, 1'b0, 1'b0);
    pulse(0, 0);
    pulse(0, 2);
    rd(0, 1'b0, 1'b0);
    pulse(0, 1);
    for (int e = 0; e < 16; e++) begin
      fw.send(8'h40 | 8'(e));
      @(posedge i_ref_clk);
      #1;
      chk("halt", o_halted, 16'hffff >> (15 - e));
      rd(e, 1'b1, 1'b0);
    end
    for (int e = 0; e < 16; e++) begin
      if (e[0]) pulse(e, 3);
      else fw.send(8'h80 | 8'(e));
      @(posedge i_ref_clk);
      #1;
      chk("unhalt", o_halted, 16'hffff << (e + 1));
    end
    repeat (60) begin
      @(posedge i_ref_clk);
      for (int e = 0; e < 16; e++) st[e] <= ebs_ep_state_t'(5'($urandom));
      if ($urandom % 4 == 0) begin
        fw.send(8'h60 | 8'($urandom % 16));
        chk("refused", o_int_clear | 16'(o_status_valid), 16'h0);
      end else rd($urandom % 16, 1'b0, 1'b0);
    end
    end_sim();
  end
endmodule
